//--- shared/rsinit_mem_if.sv
`timescale 1ns/1ps
interface rsinit_mem_if #(parameter int AW = 8);
   logic we;
   logic [AW-1:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport ctl (output we, output addr, output wdata, input rdata);
   modport mem (input we, input addr, input wdata, output rdata);
endinterface

//--- shared/rsinit_pkg.sv
// How it works
// - every reset loads ones into config, pc low, direction, wake and pin registers; mode gets 0Fh
// - accumulator, counter, port data, sram, wake pending, watchdog kept except power-on and brown-out
// - power-on clears status 7:5, sets status 4:3 to 11, leaves 2:0 undefined
// - wakeup keeps status 4:0 and clears status 7:5
// - brown-out clears status 7:5, status 4:0 undefined
// - watchdog keeps status 2:0, clears 7:5, flags 00 when asleep else 01
// - external pin keeps status 2:0, clears 7:5, flags 10 when asleep else unchanged
// - pointer bit 7 forced to 1 except power-on; low bits kept except brown-out
// - comparator control bits 0, 6 and 7 set to 1 on every reset
// - every reset points the program counter at the top of program memory
// - comparator and its pin output stay disabled until software clears enables
package rsinit_pkg;
   // ****************
   // register map
   // ****************
   localparam logic [11:0] RSINIT_OFF_RTC = 12'h004;
   localparam logic [11:0] RSINIT_OFF_PCL = 12'h008;
   localparam logic [11:0] RSINIT_OFF_STATUS = 12'h00c;
   localparam logic [11:0] RSINIT_OFF_PTR = 12'h010;
   localparam logic [11:0] RSINIT_OFF_TMRCFG = 12'h020;
   localparam logic [11:0] RSINIT_OFF_MODE = 12'h024;
   localparam logic [11:0] RSINIT_OFF_ACC = 12'h028;
   localparam logic [11:0] RSINIT_OFF_CMP = 12'h02c;
   localparam logic [11:0] RSINIT_OFF_WPND = 12'h030;
   localparam logic [11:0] RSINIT_OFF_WEDGE = 12'h034;
   localparam logic [11:0] RSINIT_OFF_WEN = 12'h038;
   localparam logic [11:0] RSINIT_OFF_WDOG = 12'h03c;
   localparam logic [11:0] RSINIT_OFF_PCHI = 12'h040;
   localparam logic [11:0] RSINIT_OFF_RST = 12'h044;
   localparam logic [11:0] RSINIT_OFF_PORT = 12'h080;
   localparam logic [11:0] RSINIT_OFF_SRAM = 12'h400;
   localparam int RSINIT_NPORT = 3;
   localparam int RSINIT_NCFG = 5;
   localparam int RSINIT_SRAM_AW = 8;
   // ****************
   // reset values
   // ****************
   localparam logic [7:0] RSINIT_ONES = 8'hff;
   localparam logic [7:0] RSINIT_MODE_RST = 8'h0f;
   localparam logic [7:0] RSINIT_CMP_SET = 8'hc1;
   localparam logic [7:0] RSINIT_PTR_SET = 8'h80;
   localparam logic [7:0] RSINIT_STAT_POR = 8'h18;
   localparam logic [1:0] RSINIT_TF_WD_SLEEP = 2'b00;
   localparam logic [1:0] RSINIT_TF_WD_RUN = 2'b01;
   localparam logic [1:0] RSINIT_TF_EXT_SLEEP = 2'b10;
   localparam logic [2:0] RSINIT_PCHI_TOP = 3'h7;
   localparam int RSINIT_TF_LO = 3;
   localparam int RSINIT_CLR_LO = 5;
   typedef enum logic [2:0] {
      RSINIT_RT_POR = 3'd1,
      RSINIT_RT_WAKE = 3'd2,
      RSINIT_RT_BOR = 3'd3,
      RSINIT_RT_WDOG = 3'd4,
      RSINIT_RT_EXT = 3'd5
   } rsinit_rtype_type;
   typedef enum logic [1:0] {
      RSINIT_ST_IDLE = 2'b01,
      RSINIT_ST_ACC = 2'b10
   } rsinit_apb_type;
endpackage

//--- tb/reset_state_register_init_bench.sv
`timescale 1ns/1ps
`define CHK(n, x, g) begin checks_done++; if ((g) !== (x)) begin bad_count++; \
   $display("MISMATCH %s exp %h got %h", n, x, g); end end
module reset_state_register_init_bench import rsinit_pkg::*;;
   logic clk = 0, rst = 1, go = 0, sl = 0, psel = 0, penable = 0, pwrite = 0, e;
   logic [2:0] kind = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, q, m;
   logic pready, pslverr, cmp_enable, cmp_pin_enable, rst_req, in_sleep;
   logic [2:0] rst_kind;
   logic [10:0] program_counter;
   logic [1:0] tf;
   logic tfk;
   int bad_count = 0, checks_done = 0;
   logic [11:0] cfg [6] = '{RSINIT_OFF_PCL, RSINIT_OFF_TMRCFG, RSINIT_OFF_WEN, RSINIT_OFF_WEDGE, RSINIT_OFF_PORT,
      RSINIT_OFF_MODE};
   logic [11:0] wa [5] = '{RSINIT_OFF_ACC, RSINIT_OFF_SRAM, RSINIT_OFF_PTR, RSINIT_OFF_STATUS, RSINIT_OFF_CMP};
   logic [7:0] wv [5] = '{8'h5a, 8'ha5, 8'h35, 8'he5, 8'h00};
   logic [2:0] kl [9] = '{3'd1, 3'd2, 3'd4, 3'd4, 3'd5, 3'd5, 3'd5, 3'd3, 3'd2};
   logic sll [9] = '{0, 0, 1, 0, 0, 1, 0, 0, 0};
   always #4 clk = ~clk;
   rsinit_regs rsinit_regs_inst (.clk, .rst, .rst_req, .rst_kind, .in_sleep, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .cmp_enable, .cmp_pin_enable, .program_counter);
   rsinit_rst_src rsinit_rst_src_inst (.clk, .go, .kind, .sleep(sl), .rst_req, .rst_kind, .in_sleep);
   // ****************
   // bus tasks
   // ****************
   task results;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         bad_count++;
         results();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task chk_rd(input logic [11:0] a, input logic [31:0] k, input logic [31:0] x);
      xfer(1'b0, a, 32'h0000_0000);
      `CHK($sformatf("reg %h", a), x, q & k)
   endtask
   // ****************
   // tests
   // ****************
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      for (int j = 0; j < 6; j++) chk_rd(cfg[j], 32'hffff_ffff, j == 5 ? 32'h0000_000f : 32'h0000_00ff);
      chk_rd(RSINIT_OFF_STATUS, 32'h0000_00f8, 32'h0000_0018);
      chk_rd(RSINIT_OFF_CMP, 32'h0000_00c1, 32'h0000_00c1);
      tf = 2'b11;
      tfk = 1'b1;
      for (int i = 0; i < 9; i++) begin
         for (int j = 0; j < 6; j++) xfer(1'b1, cfg[j], 32'h0000_0000);
         for (int j = 0; j < 5; j++) xfer(1'b1, wa[j], {24'h00_0000, wv[j]});
         repeat (2) @(negedge clk);
         `CHK("cmp_enable", 1'b1, cmp_enable)
         `CHK("cmp_pin_enable", 1'b1, cmp_pin_enable)
         @(posedge clk);
         kind <= kl[i];
         sl <= sll[i];
         go <= 1'b1;
         @(posedge clk);
         go <= 1'b0;
         repeat (3) @(negedge clk);
         `CHK("program_counter", 11'h7ff, program_counter)
         `CHK("cmp_enable", 1'b0, cmp_enable)
         `CHK("cmp_pin_enable", 1'b0, cmp_pin_enable)
         for (int j = 0; j < 6; j++) chk_rd(cfg[j], 32'hffff_ffff, j == 5 ? 32'h0000_000f : 32'h0000_00ff);
         chk_rd(RSINIT_OFF_CMP, 32'h0000_00c1, 32'h0000_00c1);
         if (kl[i] != RSINIT_RT_POR && kl[i] != RSINIT_RT_BOR) begin
            chk_rd(RSINIT_OFF_ACC, 32'hffff_ffff, 32'h0000_005a);
            chk_rd(RSINIT_OFF_SRAM, 32'hffff_ffff, 32'h0000_00a5);
            chk_rd(RSINIT_OFF_PTR, 32'hffff_ffff, 32'h0000_00b5);
         end
         if (kl[i] == RSINIT_RT_BOR) chk_rd(RSINIT_OFF_PTR, 32'h0000_0080, 32'h0000_0080);
         case (kl[i])
            RSINIT_RT_POR: begin tf = 2'b11; tfk = 1'b1; end
            RSINIT_RT_BOR: tfk = 1'b0;
            RSINIT_RT_WDOG: begin tf = sll[i] ? 2'b00 : 2'b01; tfk = 1'b1; end
            RSINIT_RT_EXT: if (sll[i]) begin tf = 2'b10; tfk = 1'b1; end
            default: ;
         endcase
         m = kl[i] == RSINIT_RT_POR ? 32'h0000_00f8 : kl[i] == RSINIT_RT_BOR ? 32'h0000_00e0 :
            tfk ? 32'h0000_00ff : 32'h0000_00e7;
         chk_rd(RSINIT_OFF_STATUS, m, {24'h00_0000, 3'b000, tf, 3'b101} & m);
         $display("test %0d done", i);
      end
      xfer(1'b0, 12'h0fc, 32'h0000_0000);
      `CHK("pslverr", 1'b1, e)
      `CHK("prdata", 32'h0000_0000, q)
      $display("test unmapped done");
      results();
   end
endmodule

//--- tb/rsinit_monitor.sv
`timescale 1ns/1ps
module rsinit_monitor (
   input wire logic clk,
   input wire logic rst,
   input wire logic rst_req,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic cmp_enable,
   input wire logic cmp_pin_enable,
   input wire logic [10:0] program_counter
);
   // ****************
   // checks
   // ****************
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_pc_top; rst_req |-> ##[1:2] program_counter == 11'h7ff; endproperty
   a_pc_top: assert property (p_pc_top) else $error("pc not at top");
   property p_cmp_off; rst_req |-> ##[1:2] (!cmp_enable && !cmp_pin_enable); endproperty
   a_cmp_off: assert property (p_cmp_off) else $error("comparator not off");
   property p_answer; psel && !penable |-> ##[1:2] pready; endproperty
   a_answer: assert property (p_answer) else $error("no ready");
   property p_stand; pready |=> !pready; endproperty
   a_stand: assert property (p_stand) else $error("ready too long");
   property p_hold;
      !rst_req && !$past(rst_req) && !pwrite && !$past(pwrite) |=> $stable(program_counter) && $stable(cmp_enable);
   endproperty
   a_hold: assert property (p_hold) else $error("state moved");
   property p_pin; cmp_pin_enable |-> cmp_enable; endproperty
   a_pin: assert property (p_pin) else $error("pin on with comparator off");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_init; $fell(rst) |-> program_counter == 11'h7ff && !cmp_enable; endproperty
   a_init: assert property (p_init) else $error("bad state after reset");
endmodule
bind rsinit_regs rsinit_monitor rsinit_monitor_inst (.clk, .rst, .rst_req, .psel, .penable, .pwrite, .pready,
   .pslverr, .cmp_enable, .cmp_pin_enable, .program_counter);

//--- tb/rsinit_rst_src.sv
`timescale 1ns/1ps
module rsinit_rst_src (
   input wire logic clk,
   input wire logic go,
   input wire logic [2:0] kind,
   input wire logic sleep,
   output logic rst_req,
   output logic [2:0] rst_kind,
   output logic in_sleep
);
   // ****************
   // one-cycle reset request, kind is invalid between requests
   // ****************
   always_ff @(posedge clk) begin
      rst_req <= go;
      rst_kind <= go ? kind : 3'h0;
      in_sleep <= go ? sleep : ~sleep;
   end
endmodule

//--- verilog/rsinit_regs.sv
`timescale 1ns/1ps
module rsinit_regs import rsinit_pkg::*; #(
   parameter int NPORT = RSINIT_NPORT
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic rst_req,
   input wire logic [2:0] rst_kind,
   input wire logic in_sleep,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic cmp_enable,
   output logic cmp_pin_enable,
   output logic [10:0] program_counter
);
   // ****************
   // state
   // ****************
   typedef struct packed {
      rsinit_apb_type st;
      logic [31:0] rdata;
      logic err;
      logic rdy;
      logic [7:0] acc, rtc, pcl, status, ptr, tmrcfg, mode, cmp, wpnd, wedge, wen, wdog;
      logic [2:0] pchi;
      logic [2:0] last_kind;
      logic [NPORT-1:0][7:0] dir, lat, smt, lvl, plp;
      logic sram_rd;
      logic cen;
      logic pen;
   } rsinit_state_type;
   rsinit_state_type s_r, s_nxt;
   rsinit_mem_if #(.AW(RSINIT_SRAM_AW)) mif ();
   rsinit_sram #(.AW(RSINIT_SRAM_AW)) u_sram (.clk(clk), .m(mif));
   function automatic logic [31:0] rsinit_z(input logic [7:0] v);
      return {24'h0000_00, v};
   endfunction
   wire sram_hit = paddr[11:10] == RSINIT_OFF_SRAM[11:10];
   assign mif.addr = paddr[RSINIT_SRAM_AW+1:2];
   assign mif.wdata = pwdata[7:0];
   assign mif.we = psel && penable && pwrite && s_r.st == RSINIT_ST_ACC && sram_hit && !rst_req;
   always_comb begin
      logic [4:0] pidx;
      logic [1:0] grp;
      s_nxt = s_r;
      pidx = 5'(paddr[6:2]);
      grp = pidx[4:3];
      s_nxt.rdy = 1'b0;
      s_nxt.err = 1'b0;
      // ****************
      // apb slave: setup, then one wait cycle, then ready
      // ****************
      case (s_r.st)
         RSINIT_ST_IDLE: begin
            if (psel && !penable) begin
               s_nxt.st = RSINIT_ST_ACC;
               s_nxt.sram_rd = sram_hit;
            end
         end
         RSINIT_ST_ACC: begin
            if (!s_r.rdy) begin
               s_nxt.rdy = 1'b1;
               s_nxt.rdata = 32'h0000_0000;
               if (s_r.sram_rd) begin
                  s_nxt.rdata = rsinit_z(mif.rdata);
               end else if (paddr[11:7] == RSINIT_OFF_PORT[11:7]) begin
                  if (pidx[2:0] < 3'(NPORT) && grp != 2'd3) begin
                     case (grp)
                        2'd0: s_nxt.rdata = rsinit_z(s_r.dir[pidx[2:0]]);
                        2'd1: s_nxt.rdata = rsinit_z(s_r.lat[pidx[2:0]]);
                        default: s_nxt.rdata = rsinit_z(pidx[3] ? s_r.plp[pidx[2:0]] : s_r.lvl[pidx[2:0]]);
                     endcase
                  end else if (pidx == 5'd24 + 5'(NPORT)) begin
                     s_nxt.rdata = 32'h0000_0000;
                  end else if (pidx >= 5'd24 && pidx < 5'd24 + 5'(NPORT)) begin
                     s_nxt.rdata = rsinit_z(s_r.smt[pidx[2:0]]);
                  end else begin
                     s_nxt.err = 1'b1;
                  end
                  if (pwrite && !s_nxt.err) begin
                     if (grp == 2'd3) begin
                        s_nxt.smt[pidx[2:0]] = pwdata[7:0];
                     end else if (grp == 2'd0) begin
                        s_nxt.dir[pidx[2:0]] = pwdata[7:0];
                     end else if (grp == 2'd1) begin
                        s_nxt.lat[pidx[2:0]] = pwdata[7:0];
                     end else if (pidx[3]) begin
                        s_nxt.plp[pidx[2:0]] = pwdata[7:0];
                     end else begin
                        s_nxt.lvl[pidx[2:0]] = pwdata[7:0];
                     end
                  end
               end else begin
                  case (paddr)
                     RSINIT_OFF_RTC: s_nxt.rdata = rsinit_z(s_r.rtc);
                     RSINIT_OFF_PCL: s_nxt.rdata = rsinit_z(s_r.pcl);
                     RSINIT_OFF_STATUS: s_nxt.rdata = rsinit_z(s_r.status);
                     RSINIT_OFF_PTR: s_nxt.rdata = rsinit_z(s_r.ptr);
                     RSINIT_OFF_TMRCFG: s_nxt.rdata = rsinit_z(s_r.tmrcfg);
                     RSINIT_OFF_MODE: s_nxt.rdata = rsinit_z(s_r.mode);
                     RSINIT_OFF_ACC: s_nxt.rdata = rsinit_z(s_r.acc);
                     RSINIT_OFF_CMP: s_nxt.rdata = rsinit_z(s_r.cmp);
                     RSINIT_OFF_WPND: s_nxt.rdata = rsinit_z(s_r.wpnd);
                     RSINIT_OFF_WEDGE: s_nxt.rdata = rsinit_z(s_r.wedge);
                     RSINIT_OFF_WEN: s_nxt.rdata = rsinit_z(s_r.wen);
                     RSINIT_OFF_WDOG: s_nxt.rdata = rsinit_z(s_r.wdog);
                     RSINIT_OFF_PCHI: s_nxt.rdata = {29'h0000_0000, s_r.pchi};
                     RSINIT_OFF_RST: s_nxt.rdata = {29'h0000_0000, s_r.last_kind};
                     default: s_nxt.err = 1'b1;
                  endcase
                  if (pwrite) begin
                     case (paddr)
                        RSINIT_OFF_RTC: s_nxt.rtc = pwdata[7:0];
                        RSINIT_OFF_PCL: s_nxt.pcl = pwdata[7:0];
                        // sleep and timeout flags are set only by reset
                        RSINIT_OFF_STATUS: s_nxt.status = {pwdata[7:5], s_r.status[4:3], pwdata[2:0]};
                        RSINIT_OFF_PTR: s_nxt.ptr = pwdata[7:0];
                        RSINIT_OFF_TMRCFG: s_nxt.tmrcfg = pwdata[7:0];
                        RSINIT_OFF_MODE: s_nxt.mode = pwdata[7:0];
                        RSINIT_OFF_ACC: s_nxt.acc = pwdata[7:0];
                        RSINIT_OFF_CMP: s_nxt.cmp = pwdata[7:0];
                        RSINIT_OFF_WPND: s_nxt.wpnd = pwdata[7:0];
                        RSINIT_OFF_WEDGE: s_nxt.wedge = pwdata[7:0];
                        RSINIT_OFF_WEN: s_nxt.wen = pwdata[7:0];
                        RSINIT_OFF_WDOG: s_nxt.wdog = pwdata[7:0];
                        RSINIT_OFF_PCHI: s_nxt.pchi = pwdata[2:0];
                        default: ;
                     endcase
                  end
               end
            end else if (!(psel && penable)) begin
               s_nxt.st = RSINIT_ST_IDLE;
            end else begin
               s_nxt.st = RSINIT_ST_IDLE;
            end
         end
         default: s_nxt.st = RSINIT_ST_IDLE;
      endcase
      // ****************
      // reset-type loads, win over bus access
      // ****************
      if (rst_req) begin
         s_nxt.last_kind = rst_kind;
         s_nxt.tmrcfg = RSINIT_ONES;
         s_nxt.pcl = RSINIT_ONES;
         s_nxt.pchi = RSINIT_PCHI_TOP;
         s_nxt.mode = RSINIT_MODE_RST;
         s_nxt.wedge = RSINIT_ONES;
         s_nxt.wen = RSINIT_ONES;
         for (int i = 0; i < NPORT; i++) begin
            s_nxt.dir[i] = RSINIT_ONES;
            s_nxt.smt[i] = RSINIT_ONES;
            s_nxt.lvl[i] = RSINIT_ONES;
            s_nxt.plp[i] = RSINIT_ONES;
         end
         s_nxt.cmp = s_r.cmp | RSINIT_CMP_SET;
         // undefined fields keep their value: acc, rtc, latches, sram, wpnd, wdog
         s_nxt.status[7:RSINIT_CLR_LO] = 3'b000;
         case (rsinit_rtype_type'(rst_kind))
            RSINIT_RT_POR: begin
               s_nxt.status[4:RSINIT_TF_LO] = RSINIT_STAT_POR[4:3];
            end
            RSINIT_RT_WAKE: begin
               s_nxt.ptr = s_r.ptr | RSINIT_PTR_SET;
            end
            RSINIT_RT_BOR: begin
               s_nxt.ptr = s_r.ptr | RSINIT_PTR_SET;
            end
            RSINIT_RT_WDOG: begin
               s_nxt.ptr = s_r.ptr | RSINIT_PTR_SET;
               s_nxt.status[4:RSINIT_TF_LO] = in_sleep ? RSINIT_TF_WD_SLEEP : RSINIT_TF_WD_RUN;
            end
            RSINIT_RT_EXT: begin
               s_nxt.ptr = s_r.ptr | RSINIT_PTR_SET;
               if (in_sleep) begin
                  s_nxt.status[4:RSINIT_TF_LO] = RSINIT_TF_EXT_SLEEP;
               end
            end
            default: ;
         endcase
      end
      // comparator enables are registered so the outputs come from flops
      s_nxt.cen = ~s_nxt.cmp[0];
      s_nxt.pen = ~s_nxt.cmp[0] & ~s_nxt.cmp[6];
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
         s_r.st <= RSINIT_ST_IDLE;
         s_r.tmrcfg <= RSINIT_ONES;
         s_r.pcl <= RSINIT_ONES;
         s_r.pchi <= RSINIT_PCHI_TOP;
         s_r.mode <= RSINIT_MODE_RST;
         s_r.wedge <= RSINIT_ONES;
         s_r.wen <= RSINIT_ONES;
         s_r.cmp <= RSINIT_CMP_SET;
         s_r.status <= RSINIT_STAT_POR;
         s_r.last_kind <= 3'(RSINIT_RT_POR);
         s_r.dir <= '1;
         s_r.smt <= '1;
         s_r.lvl <= '1;
         s_r.plp <= '1;
      end else begin
         s_r <= s_nxt;
      end
   end
   // ****************
   // outputs
   // ****************
   assign prdata = s_r.rdata;
   assign pready = s_r.rdy;
   assign pslverr = s_r.err;
   assign cmp_enable = s_r.cen;
   assign cmp_pin_enable = s_r.pen;
   assign program_counter = {s_r.pchi, s_r.pcl};
endmodule

//--- verilog/rsinit_sram.sv
`timescale 1ns/1ps
// sram keeps its contents across every reset
module rsinit_sram #(parameter int AW = 8) (
   input wire clk,
   rsinit_mem_if.mem m
);
   logic [7:0] mem_r [0:(1<<AW)-1];
   logic [7:0] rd_r;
   always_ff @(posedge clk) begin
      if (m.we) begin
         mem_r[m.addr] <= m.wdata;
      end
      rd_r <= mem_r[m.addr];
   end
   assign m.rdata = rd_r;
endmodule
